/* File: arith_if.sv */
// Operand and result bundle between the slice and its ripple arithmetic unit
`timescale 1ns/10ps
interface arith_if;
	import cls_pkg::*;
	arith_op_e op;
	logic [ARITH_W-1:0] a;
	logic [ARITH_W-1:0] b;
	logic cin;
	logic dyn_sub;
	logic mul_bit;
	logic [ARITH_W-1:0] sum;
	logic cout;
	logic gen;
	logic prop;
	logic ge;
	logic ne;
	logic le;

	modport core (
		input op, a, b, cin, dyn_sub, mul_bit,
		output sum, cout, gen, prop, ge, ne, le
	);
	modport user (
		output op, a, b, cin, dyn_sub, mul_bit,
		input sum, cout, gen, prop, ge, ne, le
	);
endinterface

/* File: chain_neighbour.sv */
// Neighbouring slice feeding a second five-input function into the chain
`timescale 1ns/10ps
module chain_neighbour #(
	parameter logic [31:0] TABLE = 32'h00000000
) (
	input wire logic [4:0] sel_i,
	output logic f_o
);
	// Same inputs as the slice, so chain select acts as a sixth input
	assign f_o = TABLE[sel_i];
endmodule // chain_neighbour

/* File: cls_pkg.sv */
// Shared constants and types of the configurable logic slice
package cls_pkg;
	// ************************************************************
	// Widths and sizes
	// ************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int LUT_AW = 4;
	localparam int LUT_DEPTH = 16;
	localparam int NUM_COLS = 4;
	localparam int ARITH_W = 2;

	// ************************************************************
	// Modes and operations
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_LOGIC = 2'h0,
		MODE_RIPPLE = 2'h1,
		MODE_RAM = 2'h2,
		MODE_ROM = 2'h3
	} slice_mode_e;

	typedef enum logic [1:0] {
		OP_ADD = 2'h0,
		OP_SUB = 2'h1,
		OP_DYN = 2'h2,
		OP_MUL = 2'h3
	} arith_op_e;

	typedef enum logic [1:0] {
		CNT_UP = 2'h0,
		CNT_DOWN = 2'h1,
		CNT_UPDOWN = 2'h2,
		CNT_HOLD = 2'h3
	} cnt_mode_e;

	// ************************************************************
	// Register offsets, fields and reset values
	// ************************************************************
	localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LUT0 = 4'h1;
	localparam logic [ADDR_W-1:0] REG_LUT3 = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;

	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_FAST = 2;
	localparam int CFG_PDP = 3;
	localparam int CFG_OP_LSB = 4;
	localparam int CFG_CNT_LSB = 6;
	localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CFG_MASK = 16'h00ff;

	localparam int STAT_CNT_LSB = 0;
	localparam int STAT_GE = 2;
	localparam int STAT_NE = 3;
	localparam int STAT_LE = 4;
	localparam int STAT_GEN = 5;
	localparam int STAT_PROP = 6;
	localparam int STAT_COUT = 7;

	localparam logic [LUT_DEPTH-1:0] LUT_INIT0 = 16'h0000;
	localparam logic [LUT_DEPTH-1:0] LUT_INIT1 = 16'h0000;
	localparam logic [LUT_DEPTH-1:0] LUT_INIT2 = 16'h0000;
	localparam logic [LUT_DEPTH-1:0] LUT_INIT3 = 16'h0000;
endpackage

/* File: configurable_logic_slice.sv */
// Configurable logic slice: lookup logic, ripple arithmetic, distributed RAM and ROM
//
// What this block does
// - The slice runs in one of four modes: logic, ripple arithmetic, RAM or ROM.
// - In logic mode each lookup element returns a programmed bit for each of 16 input patterns.
// - The two lookup elements of one slice combine into one five-input function.
// - Six- to eight-input functions come from chaining slices; eight inputs need more than four.
// - Ripple mode adds, subtracts, or adds/subtracts 2 bits by a dynamic control.
// - Ripple mode counts 2 bits up, down, or up/down with an asynchronous clear.
// - The up/down counter has a preload that loads a new count on the clock.
// - Ripple mode compares A and B for greater-or-equal, not-equal and less-or-equal.
// - Ripple mode offers a multiplier cell for building multipliers from slices.
// - Fast-carry configuration gives a carry-generate and carry-propagate per slice.
// - RAM mode builds a 16x4 memory from the four lookup elements of two slices.
// - A third slice supplies the address and write controls shared by the columns.
// - Single-port and pseudo dual-port 16x4 memories each fit in three slices.
// - Memory contents start from configured values, never undefined.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module configurable_logic_slice (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [cls_pkg::ADDR_W-1:0] BUS_ADDR_I,
	input wire logic [cls_pkg::DATA_W-1:0] BUS_WDATA_I,
	input wire logic BUS_WR_I,
	input wire logic BUS_RD_I,
	output logic [cls_pkg::DATA_W-1:0] BUS_RDATA_O,
	input wire logic [4:0] LUT_IN_I,
	input wire logic CHAIN_SEL_I,
	input wire logic CHAIN_F_I,
	output logic [1:0] LUT_F_O,
	output logic F5_O,
	output logic WIDE_O,
	input wire logic RAM_WE_I,
	input wire logic [cls_pkg::LUT_AW-1:0] RAM_WADDR_I,
	input wire logic [cls_pkg::LUT_AW-1:0] RAM_RADDR_I,
	input wire logic [cls_pkg::NUM_COLS-1:0] RAM_WDATA_I,
	output logic [cls_pkg::NUM_COLS-1:0] RAM_RDATA_O,
	input wire logic [cls_pkg::ARITH_W-1:0] ARITH_A_I,
	input wire logic [cls_pkg::ARITH_W-1:0] ARITH_B_I,
	input wire logic CARRY_I,
	input wire logic ADDSUB_I,
	input wire logic MUL_BIT_I,
	output logic [cls_pkg::ARITH_W-1:0] SUM_O,
	output logic CARRY_O,
	output logic GEN_O,
	output logic PROP_O,
	output logic GE_O,
	output logic NE_O,
	output logic LE_O,
	input wire logic CNT_EN_I,
	input wire logic CNT_LOAD_I,
	input wire logic [cls_pkg::ARITH_W-1:0] CNT_PRELOAD_I,
	input wire logic CNT_CLR_I,
	output logic [cls_pkg::ARITH_W-1:0] CNT_O
);
	import cls_pkg::*;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Look-ahead terms are written for two bits only
	if (ARITH_W != 2) begin : g_bad_arith_w
		$error("ripple unit supports a width of two bits only");
	end
	// Four storage columns make up the memory word
	if (NUM_COLS != 4) begin : g_bad_cols
		$error("memory word needs exactly four lookup columns");
	end
	// Every element holds one bit per input pattern
	if (LUT_DEPTH != (1 << LUT_AW)) begin : g_bad_depth
		$error("lookup depth must match its address width");
	end
	// A whole column moves in one register word
	if (DATA_W < LUT_DEPTH) begin : g_bad_data_w
		$error("register word narrower than a lookup column");
	end
	// Column registers sit at consecutive offsets
	if (int'(REG_LUT3) - int'(REG_LUT0) + 1 != NUM_COLS) begin : g_bad_map
		$error("column register range does not match the column count");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] rdata;
		logic [ARITH_W-1:0] cnt;
	} slice_s;

	slice_s st;
	slice_s next_st;

	// ************************************************************
	// Configuration fields
	// ************************************************************
	slice_mode_e mode;
	arith_op_e op;
	cnt_mode_e cnt_mode;
	logic fast_en;
	logic pdp_en;

	assign mode = slice_mode_e'(st.cfg[CFG_MODE_LSB +: 2]);
	assign fast_en = st.cfg[CFG_FAST];
	assign pdp_en = st.cfg[CFG_PDP];
	assign op = arith_op_e'(st.cfg[CFG_OP_LSB +: 2]);
	assign cnt_mode = cnt_mode_e'(st.cfg[CFG_CNT_LSB +: 2]);

	function automatic logic is_lut_reg(input logic [ADDR_W-1:0] addr);
		return (addr >= REG_LUT0) && (addr <= REG_LUT3);
	endfunction

	function automatic logic [1:0] lut_index(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] diff;
		diff = addr - REG_LUT0;
		return diff[1:0];
	endfunction

	// ************************************************************
	// Lookup columns: slices 0 and 1, two elements each
	// ************************************************************
	localparam logic [LUT_DEPTH-1:0] INIT_TAB [NUM_COLS] = '{LUT_INIT0, LUT_INIT1, LUT_INIT2, LUT_INIT3};

	logic [LUT_AW-1:0] col_raddr;
	logic [LUT_AW-1:0] shared_addr;
	logic col_we;
	logic [NUM_COLS-1:0] col_rd;
	logic [LUT_DEPTH-1:0] col_bits [NUM_COLS];
	logic [NUM_COLS-1:0] col_load;

	// Third slice: one address and one write enable feed all columns
	assign shared_addr = RAM_WADDR_I;
	// ROM and logic modes never take user writes
	assign col_we = (mode == MODE_RAM) && RAM_WE_I;

	always_comb begin
		case (mode)
			MODE_LOGIC: col_raddr = LUT_IN_I[LUT_AW-1:0];
			MODE_RAM: col_raddr = pdp_en ? RAM_RADDR_I : shared_addr;
			MODE_ROM: col_raddr = RAM_RADDR_I;
			default: col_raddr = shared_addr;
		endcase
	end

	for (genvar i = 0; i < NUM_COLS; i++) begin : g_col
		assign col_load[i] = BUS_WR_I && is_lut_reg(BUS_ADDR_I) && (lut_index(BUS_ADDR_I) == 2'(i));

		lookup_column #(
			.INIT(INIT_TAB[i])
		) u_col (
			.clk_i(CLK_I),
			.rstn_i(RSTN_I),
			.load_i(col_load[i]),
			.load_data_i(BUS_WDATA_I),
			.we_i(col_we),
			.waddr_i(shared_addr),
			.wdata_i(RAM_WDATA_I[i]),
			.raddr_i(col_raddr),
			.rdata_o(col_rd[i]),
			.contents_o(col_bits[i])
		);
	end

	// ************************************************************
	// Logic mode outputs
	// ************************************************************
	logic f5;

	// Fifth input picks between the two elements of the slice
	assign f5 = LUT_IN_I[4] ? col_rd[1] : col_rd[0];

	always_comb begin
		if (mode == MODE_LOGIC) begin
			LUT_F_O = col_rd[1:0];
			F5_O = f5;
			// Wider functions mux this slice against a neighbour's result
			WIDE_O = CHAIN_SEL_I ? CHAIN_F_I : f5;
		end else begin
			LUT_F_O = 2'h0;
			F5_O = 1'b0;
			WIDE_O = 1'b0;
		end
	end

	// Memory read port: live in RAM and ROM modes only
	assign RAM_RDATA_O = ((mode == MODE_RAM) || (mode == MODE_ROM)) ? col_rd : 4'h0;

	// ************************************************************
	// Ripple arithmetic
	// ************************************************************
	arith_if ar ();

	assign ar.op = op;
	assign ar.a = ARITH_A_I;
	assign ar.b = ARITH_B_I;
	assign ar.cin = CARRY_I;
	assign ar.dyn_sub = ADDSUB_I;
	assign ar.mul_bit = MUL_BIT_I;

	ripple_arith u_arith (
		.port_a(ar.core)
	);

	logic ripple;

	assign ripple = mode == MODE_RIPPLE;

	always_comb begin
		if (ripple) begin
			SUM_O = ar.sum;
			CARRY_O = ar.cout;
			GE_O = ar.ge;
			NE_O = ar.ne;
			LE_O = ar.le;
			// Look-ahead terms only exist in the fast-carry setup
			GEN_O = fast_en & ar.gen;
			PROP_O = fast_en & ar.prop;
		end else begin
			SUM_O = 2'h0;
			CARRY_O = 1'b0;
			GE_O = 1'b0;
			NE_O = 1'b0;
			LE_O = 1'b0;
			GEN_O = 1'b0;
			PROP_O = 1'b0;
		end
	end

	// ************************************************************
	// Counter
	// ************************************************************
	function automatic logic [ARITH_W-1:0] step(input logic [ARITH_W-1:0] v, input logic down);
		return down ? ARITH_W'(v - 1'b1) : ARITH_W'(v + 1'b1);
	endfunction

	logic [ARITH_W-1:0] cnt_next;

	always_comb begin
		cnt_next = st.cnt;
		if (CNT_CLR_I) begin
			cnt_next = '0;
		end else if (ripple && CNT_LOAD_I) begin
			cnt_next = CNT_PRELOAD_I;
		end else if (ripple && CNT_EN_I) begin
			case (cnt_mode)
				CNT_UP: cnt_next = step(st.cnt, 1'b0);
				CNT_DOWN: cnt_next = step(st.cnt, 1'b1);
				CNT_UPDOWN: cnt_next = step(st.cnt, ADDSUB_I);
				default: cnt_next = st.cnt;
			endcase
		end
	end

	// Clear masks the output at once, without waiting for an edge
	assign CNT_O = CNT_CLR_I ? '0 : st.cnt;

	// ************************************************************
	// Register port
	// ************************************************************
	logic [DATA_W-1:0] stat_word;

	always_comb begin
		stat_word = '0;
		stat_word[STAT_CNT_LSB +: ARITH_W] = CNT_O;
		stat_word[STAT_GE] = GE_O;
		stat_word[STAT_NE] = NE_O;
		stat_word[STAT_LE] = LE_O;
		stat_word[STAT_GEN] = GEN_O;
		stat_word[STAT_PROP] = PROP_O;
		stat_word[STAT_COUT] = CARRY_O;
	end

	always_comb begin
		next_st = st;
		next_st.cnt = cnt_next;
		if (BUS_WR_I && (BUS_ADDR_I == REG_CFG)) begin
			next_st.cfg = BUS_WDATA_I & CFG_MASK;
		end
		// Read data stands only in the cycle after the strobe
		next_st.rdata = '0;
		if (BUS_RD_I) begin
			if (BUS_ADDR_I == REG_CFG) begin
				next_st.rdata = st.cfg;
			end else if (is_lut_reg(BUS_ADDR_I)) begin
				next_st.rdata = col_bits[lut_index(BUS_ADDR_I)];
			end else if (BUS_ADDR_I == REG_STAT) begin
				next_st.rdata = stat_word;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			st.cfg <= CFG_RESET;
			st.rdata <= '0;
			st.cnt <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign BUS_RDATA_O = st.rdata;
endmodule // configurable_logic_slice

/* File: configurable_logic_slice_properties.sv */
// Port-level assertions of the configurable logic slice
`timescale 1ns/10ps
module slice_checker (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [3:0] BUS_ADDR_I,
	input wire logic [15:0] BUS_WDATA_I,
	input wire logic BUS_WR_I,
	input wire logic BUS_RD_I,
	input wire logic [15:0] BUS_RDATA_O,
	input wire logic [4:0] LUT_IN_I,
	input wire logic CHAIN_SEL_I,
	input wire logic CHAIN_F_I,
	input wire logic [1:0] LUT_F_O,
	input wire logic F5_O,
	input wire logic WIDE_O,
	input wire logic RAM_WE_I,
	input wire logic [3:0] RAM_WADDR_I,
	input wire logic [3:0] RAM_WDATA_I,
	input wire logic [3:0] RAM_RDATA_O,
	input wire logic [1:0] ARITH_A_I,
	input wire logic [1:0] ARITH_B_I,
	input wire logic GE_O,
	input wire logic NE_O,
	input wire logic LE_O,
	input wire logic CNT_EN_I,
	input wire logic CNT_LOAD_I,
	input wire logic [1:0] CNT_PRELOAD_I,
	input wire logic CNT_CLR_I,
	input wire logic [1:0] CNT_O
);
	import cls_pkg::*;
	// ****
	// Shadow of the low configuration byte
	// ****
	logic [7:0] cfg;
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			cfg <= 8'h00;
		end else if (BUS_WR_I && BUS_ADDR_I == REG_CFG) begin
			cfg <= BUS_WDATA_I[7:0];
		end
	end
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// ****
	// Assertions
	// ****
	a_rd_idle_zero: assert property (!$past(BUS_RD_I) |-> BUS_RDATA_O == 16'h0000)
		else $error("read data not zero outside read slot");
	a_clr_forces_zero: assert property (CNT_CLR_I |-> CNT_O == 2'h0)
		else $error("count not cleared");
	a_preload_taken: assert property (cfg[1:0] == MODE_RIPPLE && CNT_LOAD_I && !CNT_CLR_I
		|=> CNT_CLR_I || CNT_O == $past(CNT_PRELOAD_I)) else $error("preload not taken");
	a_up_step: assert property (cfg[1:0] == MODE_RIPPLE && cfg[7:6] == CNT_UP && CNT_EN_I && !CNT_LOAD_I
		&& !CNT_CLR_I |=> CNT_CLR_I || CNT_O == 2'($past(CNT_O) + 2'h1)) else $error("up step wrong");
	a_logic_outputs_gated: assert property (cfg[1:0] != MODE_LOGIC
		|-> LUT_F_O == 2'h0 && !F5_O && !WIDE_O) else $error("lookup outputs active outside logic mode");
	a_compare_flags: assert property (cfg[1:0] == MODE_RIPPLE |-> GE_O == (ARITH_A_I >= ARITH_B_I)
		&& NE_O == (ARITH_A_I != ARITH_B_I) && LE_O == (ARITH_A_I <= ARITH_B_I)) else $error("compare wrong");
	a_five_input_join: assert property (cfg[1:0] == MODE_LOGIC |-> F5_O == LUT_F_O[LUT_IN_I[4]]
		&& WIDE_O == (CHAIN_SEL_I ? CHAIN_F_I : F5_O)) else $error("five-input join wrong");
	a_ram_write_read: assert property (cfg[1:0] == MODE_RAM && !cfg[3] && RAM_WE_I && !BUS_WR_I
		##1 RAM_WADDR_I == $past(RAM_WADDR_I) |-> RAM_RDATA_O == $past(RAM_WDATA_I)) else $error("ram write lost");
endmodule // slice_checker

/* File: configurable_logic_slice_tb_top.sv */
// Self-checking bench of the configurable logic slice
`timescale 1ns/10ps
module configurable_logic_slice_tb_top;
	import cls_pkg::*;
	localparam logic [31:0] NB_TABLE = 32'h6ac319f4;
	logic CLK_I, RSTN_I, BUS_WR_I, BUS_RD_I, CHAIN_SEL_I, RAM_WE_I, CARRY_I, ADDSUB_I, MUL_BIT_I;
	logic CNT_EN_I, CNT_LOAD_I, CNT_CLR_I, F5_O, WIDE_O, CARRY_O, GEN_O, PROP_O, GE_O, NE_O, LE_O;
	logic [3:0] BUS_ADDR_I, RAM_WADDR_I, RAM_RADDR_I, RAM_WDATA_I, RAM_RDATA_O;
	logic [15:0] BUS_WDATA_I, BUS_RDATA_O;
	logic [4:0] LUT_IN_I;
	logic [1:0] LUT_F_O, ARITH_A_I, ARITH_B_I, SUM_O, CNT_PRELOAD_I, CNT_O, cnt, x, y;
	wire logic CHAIN_F_I;
	logic [15:0] lut [4];
	logic [2:0] s;
	logic [3:0] a;
	logic ram_ok;
	int err_total = 0;
	int compares = 0;

	configurable_logic_slice i_dut (.*);
	chain_neighbour #(.TABLE(NB_TABLE)) i_nb (.sel_i(LUT_IN_I), .f_o(CHAIN_F_I));

	initial begin
		CLK_I = 1'h0;
		forever #4 CLK_I = ~CLK_I;
	end
	// ****
	// Shared tasks
	// ****
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [3:0] ad, logic [15:0] d);
		@(posedge CLK_I);
		BUS_WR_I <= 1'h1;
		BUS_ADDR_I <= ad;
		BUS_WDATA_I <= d;
		if (ad inside {[1:4]}) lut[ad - 1] = d;
		@(posedge CLK_I);
		BUS_WR_I <= 1'h0;
	endtask
	task automatic rd(logic [3:0] ad, logic [15:0] exp, string what);
		@(posedge CLK_I);
		BUS_RD_I <= 1'h1;
		BUS_ADDR_I <= ad;
		@(posedge CLK_I);
		BUS_RD_I <= 1'h0;
		@(negedge CLK_I);
		chk(what, exp, BUS_RDATA_O);
	endtask
	// Pending write lands at the edge, read is checked once it settles
	task automatic mem_cyc(logic we, logic [3:0] wa, logic [3:0] ra, logic by_ra);
		@(posedge CLK_I);
		if (RAM_WE_I && ram_ok) for (int c = 0; c < 4; c++) lut[c][RAM_WADDR_I] = RAM_WDATA_I[c];
		RAM_WE_I <= we;
		RAM_WADDR_I <= wa;
		RAM_RADDR_I <= ra;
		RAM_WDATA_I <= 4'($urandom);
		@(negedge CLK_I);
		a = by_ra ? RAM_RADDR_I : RAM_WADDR_I;
		chk("ram word", {lut[3][a], lut[2][a], lut[1][a], lut[0][a]}, RAM_RDATA_O);
	endtask
	task automatic cnt_upd(int m);
		@(posedge CLK_I);
		if (CNT_CLR_I) cnt = 2'h0;
		else if (CNT_LOAD_I) cnt = CNT_PRELOAD_I;
		else if (CNT_EN_I && m != 3) cnt = (m == 1 || m == 2 && ADDSUB_I) ? cnt - 2'h1 : cnt + 2'h1;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****
	// Stimulus
	// ****
	initial begin
		{RSTN_I, BUS_WR_I, BUS_RD_I, CHAIN_SEL_I, RAM_WE_I, CARRY_I, ADDSUB_I, MUL_BIT_I} = 8'h00;
		{CNT_EN_I, CNT_LOAD_I, CNT_CLR_I, CNT_PRELOAD_I, ARITH_A_I, ARITH_B_I} = 9'h000;
		{BUS_ADDR_I, RAM_WADDR_I, RAM_RADDR_I, RAM_WDATA_I, LUT_IN_I, BUS_WDATA_I} = 37'h0;
		for (int c = 0; c < 4; c++) lut[c] = 16'h0000;
		cnt = 2'h0;
		ram_ok = 1'h0;
		void'($urandom(96736));
		repeat (20) @(posedge CLK_I);
		RSTN_I <= 1'h1;
		for (int r = 0; r < 16; r++) rd(r[3:0], 16'h0000, "reset reg");
		for (int c = 0; c < 4; c++) wr(4'(REG_LUT0 + c), 16'($urandom));
		wr(REG_CFG, 16'hff00);
		rd(REG_CFG, 16'h0000, "cfg upper");
		for (int i = 0; i < 64; i++) begin
			@(posedge CLK_I);
			LUT_IN_I <= i[4:0];
			CHAIN_SEL_I <= i[5];
			@(negedge CLK_I);
			a = LUT_IN_I[3:0];
			s = {lut[1][a], lut[0][a], lut[LUT_IN_I[4]][a]};
			chk("logic", {s, CHAIN_SEL_I ? NB_TABLE[LUT_IN_I] : s[0]}, {LUT_F_O, F5_O, WIDE_O});
		end
		for (int j = 0; j < 8; j++) begin
			wr(REG_CFG, {10'h000, j[1:0], 1'h0, j[2], 2'h1});
			repeat (16) begin
				@(posedge CLK_I);
				{ARITH_A_I, ARITH_B_I, CARRY_I, ADDSUB_I, MUL_BIT_I} <= 7'($urandom);
				@(negedge CLK_I);
				x = (j[1:0] == OP_MUL) ? ARITH_A_I & {2{MUL_BIT_I}} : ARITH_A_I;
				y = (j[1:0] == OP_SUB || j[1:0] == OP_DYN && ADDSUB_I) ? ~ARITH_B_I : ARITH_B_I;
				s = x + y + CARRY_I;
				chk("ripple", {s, ARITH_A_I >= ARITH_B_I, ARITH_A_I != ARITH_B_I, ARITH_A_I <= ARITH_B_I},
					{CARRY_O, SUM_O, GE_O, NE_O, LE_O});
				chk("carry terms", j[2] ? {x[1] & y[1] | (x[1] ^ y[1]) & x[0] & y[0], s[2]} : 2'h0,
					j[2] ? {GEN_O, GEN_O | PROP_O & CARRY_I} : {GEN_O, PROP_O});
			end
			rd(REG_STAT, {8'h00, s[2], {2{j[2]}} & {&(x ^ y), x[1] & y[1] | (x[1] ^ y[1]) & x[0] & y[0]},
				(ARITH_A_I <= ARITH_B_I), (ARITH_A_I != ARITH_B_I), (ARITH_A_I >= ARITH_B_I), cnt}, "status");
		end
		for (int m = 0; m < 4; m++) begin
			wr(REG_CFG, {8'h00, m[1:0], 6'h01});
			repeat (12) begin
				cnt_upd(m);
				{CNT_EN_I, CNT_PRELOAD_I, ADDSUB_I} <= 4'($urandom);
				CNT_LOAD_I <= ($urandom % 5 == 0);
				CNT_CLR_I <= ($urandom % 7 == 0);
				@(negedge CLK_I);
				chk("count", CNT_CLR_I ? 2'h0 : cnt, CNT_O);
			end
			cnt_upd(m);
			{CNT_EN_I, CNT_LOAD_I, CNT_CLR_I} <= 3'h0;
		end
		ram_ok = 1'h1;
		wr(REG_CFG, 16'h0002);
		// Each address twice in a row, so write-then-read is seen at one address
		for (int r = 0; r < 32; r++) mem_cyc(1'h1, r[4:1], ~r[3:0], 1'h0);
		mem_cyc(1'h0, 4'h0, 4'h0, 1'h0);
		wr(REG_CFG, 16'h000a);
		for (int r = 0; r < 16; r++) mem_cyc(1'h1, 4'($urandom), r[3:0], 1'h1);
		mem_cyc(1'h0, 4'h0, 4'h0, 1'h1);
		wr(REG_CFG, 16'h0003);
		ram_ok = 1'h0;
		for (int r = 0; r < 17; r++) mem_cyc(r < 16, 4'($urandom), r[3:0], 1'h1);
		for (int c = 0; c < 4; c++) rd(4'(REG_LUT0 + c), lut[c], "column");
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge CLK_I);
		err_total++;
		tally_and_finish();
	end
endmodule // configurable_logic_slice_tb_top

bind configurable_logic_slice slice_checker i_chk (.*);

/* File: lookup_column.sv */
// One 16x1 lookup element, usable as truth table or storage column
`timescale 1ns/10ps
module lookup_column #(
	parameter logic [15:0] INIT = 16'h0000
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic load_i,
	input wire logic [15:0] load_data_i,
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic wdata_i,
	input wire logic [3:0] raddr_i,
	output logic rdata_o,
	output logic [15:0] contents_o
);
	typedef struct packed {
		logic [15:0] bits;
	} col_s;

	col_s st;
	col_s next_st;

	always_comb begin
		next_st = st;
		if (load_i) begin
			next_st.bits = load_data_i;
		end else if (we_i) begin
			next_st.bits[waddr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st.bits <= INIT;
		end else begin
			st <= next_st;
		end
	end

	// Read stays asynchronous, as in a real lookup element
	assign rdata_o = st.bits[raddr_i];
	assign contents_o = st.bits;
endmodule // lookup_column

/* File: ripple_arith.sv */
// Two-bit ripple arithmetic, compare and carry look-ahead terms
`timescale 1ns/10ps
module ripple_arith (
	arith_if.core port_a
);
	import cls_pkg::*;

	logic do_sub;
	logic [ARITH_W-1:0] x;
	logic [ARITH_W-1:0] y;
	logic [ARITH_W-1:0] g;
	logic [ARITH_W-1:0] p;
	logic [ARITH_W:0] total;

	always_comb begin
		do_sub = (port_a.op == OP_SUB) || ((port_a.op == OP_DYN) && port_a.dyn_sub);
		if (port_a.op == OP_MUL) begin
			// Partial sum in b plus one partial product row
			x = port_a.b;
			y = port_a.a & {ARITH_W{port_a.mul_bit}};
		end else begin
			x = port_a.a;
			y = do_sub ? ~port_a.b : port_a.b;
		end
		total = {1'b0, x} + {1'b0, y} + {{ARITH_W{1'b0}}, port_a.cin};
		g = x & y;
		p = x ^ y;
	end

	assign port_a.sum = total[ARITH_W-1:0];
	assign port_a.cout = total[ARITH_W];
	assign port_a.gen = g[1] | (p[1] & g[0]);
	assign port_a.prop = p[1] & p[0];
	assign port_a.ge = port_a.a >= port_a.b;
	assign port_a.ne = port_a.a != port_a.b;
	assign port_a.le = port_a.a <= port_a.b;
endmodule // ripple_arith
